// ### rtl/ocf_consts.svh
// constants of the overcurrent fault, retry and bus address configuration block
`ifndef OCF_CONSTS_SVH
`define OCF_CONSTS_SVH

`define OCF_CMD_CFG        8'hc9
`define OCF_CMD_RESP       8'hca
`define OCF_LEN_CFG        3'd5
`define OCF_LEN_RESP       3'd1
`define OCF_CFG_RST        40'h0040000000
`define OCF_RESP_RST       8'h00

`define OCF_PG_POL         39
`define OCF_CTL_POL        32
`define OCF_BASE_HI        31
`define OCF_BASE_LO        24
`define OCF_OFS_HI         23
`define OCF_OFS_LO         17
`define OCF_OFS_RES        16
`define OCF_RSP_HI         7
`define OCF_RSP_LO         6
`define OCF_RTY_HI         5
`define OCF_RTY_LO         3
`define OCF_DLY_HI         2
`define OCF_DLY_LO         0

`define OCF_RSP_IGNORE     2'b00
`define OCF_RSP_RETRY      2'b11
`define OCF_RTY_NONE       3'b000
`define OCF_RTY_CONT       3'b111

`define OCF_CLK_PERIOD_NS  10
`define OCF_UNIT_BASE_NS   1000000
`define OCF_MS_CYCLES      (`OCF_UNIT_BASE_NS / `OCF_CLK_PERIOD_NS)
`define OCF_UNIT0_MS       9'd1
`define OCF_UNIT1_MS       9'd4
`define OCF_UNIT2_MS       9'd16
`define OCF_UNIT3_MS       9'd256

`define OCF_SY_SCL         4
`define OCF_SY_SDA         3
`define OCF_SY_OC          2
`define OCF_SY_ON          1
`define OCF_SY_CLR         0

`endif

// ### rtl/ocf_pkg.sv
// types of the overcurrent fault, retry and bus address configuration block
package ocf_pkg;

    typedef enum logic [4:0] {
        I_IDLE = 5'b00001,
        I_ADDR = 5'b00010,
        I_CMD  = 5'b00100,
        I_WR   = 5'b01000,
        I_RD   = 5'b10000
    } ocf_bus_e;

    typedef enum logic [3:0] {
        F_RUN   = 4'b0001,
        F_LIMIT = 4'b0010,
        F_WAIT  = 4'b0100,
        F_OFF   = 4'b1000
    } ocf_flt_e;

    typedef struct packed {
        logic [4:0]  sy1;
        logic [4:0]  sy2;
        logic [4:0]  prv;
        logic        strap_ok;
        logic [6:0]  strap;
        logic [39:0] cfg;
        logic [7:0]  resp;
        ocf_bus_e    bst;
        logic [3:0]  bcnt;
        logic [7:0]  sh;
        logic [7:0]  cmd;
        logic        cmd_ok;
        logic [2:0]  idx;
        logic [39:0] shadow;
        logic        mack;
        ocf_flt_e    fst;
        logic [7:0]  ucnt;
        logic [2:0]  tries;
        logic        restart;
        logic        od_low;
        logic        sda_oe_n;
        logic        flag;
        logic        alert_oe_n;
        logic        out_en;
        logic        limit;
        logic        pg;
    } ocf_st_s;

endpackage

// ### rtl/ocf_tick_if.sv
// link between the fault logic and its delay unit timer
`timescale 1ns/1ps
interface ocf_tick_if;
    logic [1:0] unit_sel;
    logic       restart;
    logic       tick;

    modport gen (
        input  unit_sel,
        input  restart,
        output tick
    );
    modport user (
        output unit_sel,
        output restart,
        input  tick
    );
endinterface

// ### rtl/ocf_unit_timer.sv
// delay unit timer: one-cycle tick per selected delay unit
`timescale 1ns/1ps
`include "ocf_consts.svh"
module ocf_unit_timer
    import ocf_pkg::*;
#(
    parameter int MS_CYCLES = `OCF_MS_CYCLES
) (
    input  wire logic clock_in,
    input  wire logic rst_in,
    ocf_tick_if.gen   tif
);
    typedef struct packed {
        logic [31:0] ms;
        logic [8:0]  un;
        logic        tick;
    } ocf_tmr_s;

    ocf_tmr_s   q;
    ocf_tmr_s   n;
    logic [8:0] lim;

    always_comb begin
        unique case (tif.unit_sel)
            2'b00: lim = `OCF_UNIT0_MS;
            2'b01: lim = `OCF_UNIT1_MS;
            2'b10: lim = `OCF_UNIT2_MS;
            2'b11: lim = `OCF_UNIT3_MS;
        endcase
        n = q;
        n.tick = 1'b0;
        if (tif.restart) begin
            n.ms = '0;
            n.un = '0;
        end else if (q.ms == 32'(MS_CYCLES - 1)) begin
            n.ms = '0;
            if (q.un >= lim - 9'd1) begin
                n.un = '0;
                n.tick = 1'b1;
            end else begin
                n.un = q.un + 9'd1;
            end
        end else begin
            n.ms = q.ms + 32'd1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign tif.tick = q.tick;
endmodule

// ### rtl/ocf_top.sv
// overcurrent fault response with retry, plus bus address and pin polarity setup
`timescale 1ns/1ps
`include "ocf_consts.svh"
module ocf_top
    import ocf_pkg::*;
#(
    parameter int MS_CYCLES = `OCF_MS_CYCLES
) (
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n_out,
    input  wire logic [6:0] addr_strap_in,
    input  wire logic       fast_oc_in,
    input  wire logic       on_off_in,
    input  wire logic       clear_faults_in,
    input  wire logic [1:0] iout_delay_unit_in,
    output logic            output_enable_out,
    output logic            current_limit_out,
    output logic            power_good_out,
    output logic            fault_flag_out,
    output logic            alert_out,
    output logic            alert_oe_n_out
);
    ocf_st_s     q;
    ocf_st_s     n;
    ocf_tick_if  tif();

    logic        scl;
    logic        sda;
    logic        scl_r;
    logic        scl_f;
    logic        start;
    logic        stop;
    logic        oc;
    logic        oc_rise;
    logic        on_act;
    logic        clr;
    logic        tick;
    logic [6:0]  ofs;
    logic [7:0]  addr_sum;
    logic [6:0]  my_addr;
    logic        known;
    logic [2:0]  wr_len;
    logic [39:0] rd_src;
    logic [7:0]  rd_byte;
    logic [1:0]  mode;
    logic [2:0]  retry;
    logic [7:0]  tgt;
    logic        at_end;
    logic        pg_raw;

    ocf_unit_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_tmr (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .tif      (tif)
    );

    assign tif.unit_sel = iout_delay_unit_in;
    assign tif.restart  = q.restart;
    // a tick seen while the restart is still in flight is left over from the old count;
    // taking it would end a one-unit limit or wait period at once
    assign tick         = tif.tick & ~q.restart;

    // only the second sync stage and its delayed copy feed logic
    assign scl     = q.sy2[`OCF_SY_SCL];
    assign sda     = q.sy2[`OCF_SY_SDA];
    assign scl_r   = scl & ~q.prv[`OCF_SY_SCL];
    assign scl_f   = ~scl & q.prv[`OCF_SY_SCL];
    assign start   = scl & q.prv[`OCF_SY_SCL] & ~sda & q.prv[`OCF_SY_SDA];
    assign stop    = scl & q.prv[`OCF_SY_SCL] & sda & ~q.prv[`OCF_SY_SDA];
    assign oc      = q.sy2[`OCF_SY_OC];
    assign oc_rise = oc & ~q.prv[`OCF_SY_OC];
    assign clr     = q.sy2[`OCF_SY_CLR] & ~q.prv[`OCF_SY_CLR];
    assign on_act  = q.cfg[`OCF_CTL_POL] ? q.sy2[`OCF_SY_ON]
                                         : ~q.sy2[`OCF_SY_ON];

    // offset source: strap resistor or programmed field
    assign ofs      = q.cfg[`OCF_OFS_RES] ? q.strap
                                          : q.cfg[`OCF_OFS_HI:`OCF_OFS_LO];
    assign addr_sum = q.cfg[`OCF_BASE_HI:`OCF_BASE_LO] + {1'b0, ofs};
    assign my_addr  = addr_sum[6:0];

    assign known   = (q.cmd == `OCF_CMD_CFG) || (q.cmd == `OCF_CMD_RESP);
    assign wr_len  = (q.cmd == `OCF_CMD_CFG) ? `OCF_LEN_CFG : `OCF_LEN_RESP;
    assign rd_src  = (q.cmd == `OCF_CMD_CFG) ? q.cfg : {32'h0, q.resp};
    assign rd_byte = 8'(rd_src >> {q.idx, 3'b000});

    assign mode   = q.resp[`OCF_RSP_HI:`OCF_RSP_LO];
    assign retry  = q.resp[`OCF_RTY_HI:`OCF_RTY_LO];
    assign tgt    = 8'h01 << q.resp[`OCF_DLY_HI:`OCF_DLY_LO];
    assign at_end = tick && ((q.ucnt + 8'd1) == tgt);

    always_comb begin
        n = q;
        pg_raw = 1'b0;
        n.sy1 = {scl_in, sda_in, fast_oc_in, on_off_in, clear_faults_in};
        n.sy2 = q.sy1;
        n.prv = q.sy2;
        n.restart = 1'b0;
        // strap pins are static; take them once after reset is released
        if (!q.strap_ok) begin
            n.strap = addr_strap_in;
            n.strap_ok = 1'b1;
        end

        // ---- bus slave ----
        if (start) begin
            n.bst = I_ADDR;
            n.bcnt = '0;
            n.sda_oe_n = 1'b1;
        end else if (stop) begin
            // a write counts only if the whole register arrived
            if (q.bst == I_WR && q.cmd_ok && q.idx == wr_len) begin
                if (q.cmd == `OCF_CMD_CFG) begin
                    n.cfg = q.shadow;
                end else begin
                    n.resp = q.shadow[7:0];
                end
            end
            n.bst = I_IDLE;
            n.sda_oe_n = 1'b1;
        end else if (q.bst != I_IDLE) begin
            if (scl_r) begin
                if (q.bcnt < 4'd8) begin
                    n.sh = {q.sh[6:0], sda};
                end else begin
                    n.mack = ~sda;
                end
                n.bcnt = q.bcnt + 4'd1;
            end else if (scl_f) begin
                if (q.bcnt == 4'd8) begin
                    n.sda_oe_n = 1'b1;
                    unique case (q.bst)
                        I_ADDR: begin
                            if (q.sh[7:1] != my_addr) begin
                                n.bst = I_IDLE;
                            end else begin
                                n.sda_oe_n = 1'b0;
                                if (q.sh[0]) begin
                                    n.bst = I_RD;
                                    n.idx = '0;
                                    n.mack = 1'b1;
                                end else begin
                                    n.bst = I_CMD;
                                end
                            end
                        end
                        I_CMD: begin
                            n.cmd = q.sh;
                            n.idx = '0;
                            n.cmd_ok = (q.sh == `OCF_CMD_CFG) || (q.sh == `OCF_CMD_RESP);
                            n.sda_oe_n = ~n.cmd_ok;
                            n.bst = I_WR;
                        end
                        I_WR: begin
                            if (q.cmd_ok && q.idx < wr_len) begin
                                n.shadow[{q.idx, 3'b000} +: 8] = q.sh;
                                n.idx = q.idx + 3'd1;
                                n.sda_oe_n = 1'b0;
                            end
                        end
                        I_RD: begin
                            n.sda_oe_n = 1'b1;
                        end
                        I_IDLE: begin
                            n.bst = I_IDLE;
                        end
                    endcase
                end else if (q.bcnt == 4'd9) begin
                    n.bcnt = '0;
                    n.sda_oe_n = 1'b1;
                    if (q.bst == I_RD) begin
                        if (q.mack && known) begin
                            n.sh = rd_byte;
                            n.sda_oe_n = rd_byte[7];
                            n.idx = q.idx + 3'd1;
                        end else begin
                            n.bst = I_IDLE;
                        end
                    end
                end else if (q.bst == I_RD) begin
                    // read shift rotates our own bit back in, so msb is next
                    n.sda_oe_n = q.sh[7];
                end
            end
        end

        // ---- fault handling ----
        if (clr) begin
            n.flag = 1'b0;
        end
        if (oc_rise) begin
            n.flag = 1'b1;
        end

        unique case (q.fst)
            F_RUN: begin
                // code 00 and unlisted codes stay here and limit
                if (on_act && oc && mode == `OCF_RSP_RETRY) begin
                    n.fst = F_LIMIT;
                    n.ucnt = '0;
                    n.restart = 1'b1;
                end
            end
            F_LIMIT: begin
                if (!oc) begin
                    n.fst = F_RUN;
                end else if (at_end) begin
                    if (retry == `OCF_RTY_NONE) begin
                        n.fst = F_OFF;
                    end else if (retry != `OCF_RTY_CONT && q.tries >= retry) begin
                        n.fst = F_OFF;
                    end else begin
                        if (retry != `OCF_RTY_CONT) begin
                            n.tries = q.tries + 3'd1;
                        end
                        n.fst = F_WAIT;
                        n.ucnt = '0;
                        n.restart = 1'b1;
                    end
                end else if (tick) begin
                    n.ucnt = q.ucnt + 8'd1;
                end
            end
            F_WAIT: begin
                if (at_end) begin
                    n.fst = F_RUN;
                end else if (tick) begin
                    n.ucnt = q.ucnt + 8'd1;
                end
            end
            F_OFF: begin
                if (clr) begin
                    n.fst = F_RUN;
                    n.tries = '0;
                end
            end
        endcase
        // commanded off ends retrying, but a latched fault needs a clear
        if (!on_act && q.fst != F_OFF) begin
            n.fst = F_RUN;
            n.tries = '0;
        end

        n.out_en = on_act && (n.fst == F_RUN || n.fst == F_LIMIT);
        n.limit = n.out_en && oc;
        pg_raw = n.out_en && !oc;
        n.pg = q.cfg[`OCF_PG_POL] ? pg_raw : ~pg_raw;
        n.alert_oe_n = ~n.flag;
        n.od_low = 1'b0;
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            q <= '0;
            q.cfg <= `OCF_CFG_RST;
            q.resp <= `OCF_RESP_RST;
            q.bst <= I_IDLE;
            q.fst <= F_RUN;
            q.sda_oe_n <= 1'b1;
            q.alert_oe_n <= 1'b1;
            q.pg <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign sda_out           = q.od_low;
    assign sda_oe_n_out      = q.sda_oe_n;
    assign output_enable_out = q.out_en;
    assign current_limit_out = q.limit;
    assign power_good_out    = q.pg;
    assign fault_flag_out    = q.flag;
    assign alert_out         = q.od_low;
    assign alert_oe_n_out    = q.alert_oe_n;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    a_flag_on_fault: assert property (oc_rise |=> fault_flag_out ##0 !alert_oe_n_out)
        else $error("fault flag or alert missing after fault");
    a_ignore_keeps_run: assert property (
        (q.fst == F_RUN && mode == `OCF_RSP_IGNORE && on_act && oc && $stable(q.sy2))
        |=> q.fst == F_RUN ##0 output_enable_out ##0 current_limit_out)
        else $error("ignore mode left running state");
    a_limit_entry: assert property (
        (q.fst == F_RUN && on_act && oc && mode == `OCF_RSP_RETRY)
        |=> q.fst == F_LIMIT ##1 q.restart == 1'b0)
        else $error("retry mode did not start limiting");
    a_no_retry_off: assert property (
        (q.fst == F_LIMIT && at_end && oc && on_act && retry == `OCF_RTY_NONE)
        |=> q.fst == F_OFF ##0 !output_enable_out)
        else $error("no-retry did not latch off");
    a_off_holds: assert property (
        (q.fst == F_OFF && !clr) |=> q.fst == F_OFF ##0 !output_enable_out)
        else $error("latched off left without clear");
    a_tries_bound: assert property (
        (retry != `OCF_RTY_CONT && retry != `OCF_RTY_NONE) |-> q.tries <= retry)
        else $error("more restarts than programmed");
    a_wait_ends: assert property (
        (q.fst == F_WAIT && at_end && on_act) |=> q.fst == F_RUN)
        else $error("restart interval did not end on time");
    a_cont_retry: assert property (
        (q.fst == F_LIMIT && at_end && oc && on_act && retry == `OCF_RTY_CONT)
        |=> q.fst == F_WAIT ##0 $stable(q.tries))
        else $error("continuous retry stopped");
    a_addr_ack: assert property (
        (q.bst == I_ADDR && scl_f && q.bcnt == 4'd8 && !start && !stop
         && q.sh[7:1] == my_addr) |=> !sda_oe_n_out)
        else $error("own address not acknowledged");

    c_limit_to_wait: cover property (q.fst == F_LIMIT ##1 q.fst == F_WAIT);
    c_latched_off:   cover property (q.fst == F_OFF);
    c_read_byte:     cover property (q.bst == I_RD && scl_f && q.bcnt == 4'd9);
    c_cfg_commit:    cover property (stop && q.bst == I_WR && q.cmd == `OCF_CMD_CFG);
endmodule

// ### tb/ocf_host_model.sv
// bus host model: byte transfers with a driven bus clock and an open-drain data pin
`timescale 1ns/1ps
module ocf_host_model (
    input  wire logic clock_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    logic ph;

    initial begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
        ph          = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    // 12 and 13 cycle bits alternate to average a 125 ns bus clock
    task automatic bit_io(input logic b, output logic r);
        scl_out <= 1'b0;
        tick(3);
        sda_low_out <= ~b;
        tick(3 + int'(ph));
        ph = ~ph;
        scl_out <= 1'b1;
        tick(6);
        r = sda_in;
    endtask

    // stp low gives a start or repeated start, high gives a stop
    task automatic cond(input logic stp);
        scl_out <= 1'b0;
        tick(3);
        sda_low_out <= stp;
        tick(3);
        scl_out <= 1'b1;
        tick(6);
        sda_low_out <= ~stp;
        tick(6);
    endtask

    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                        output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], a);
            q[i] = a;
        end
        bit_io(last, a);
        ack = ~a;
    endtask

    task automatic write_reg(input logic [6:0] a, input logic [7:0] c, input int n,
                             input logic [39:0] v, output logic ok);
        logic [7:0] q;
        logic       k;
        cond(1'b0);
        xfer({a, 1'b0}, 1'b1, q, ok);
        xfer(c, 1'b1, q, k);
        ok = ok & k;
        for (int i = 0; i < n; i++) begin
            xfer(v[8*i +: 8], 1'b1, q, k);
            ok = ok & k;
        end
        cond(1'b1);
    endtask

    task automatic read_reg(input logic [6:0] a, input logic [7:0] c, input int n,
                            output logic [39:0] v, output logic ok);
        logic [7:0] q;
        logic       k;
        v = 40'h0;
        cond(1'b0);
        xfer({a, 1'b0}, 1'b1, q, ok);
        xfer(c, 1'b1, q, k);
        ok = ok & k;
        cond(1'b0);
        xfer({a, 1'b1}, 1'b1, q, k);
        ok = ok & k;
        for (int i = 0; i < n; i++) begin
            xfer(8'hff, i == n - 1, q, k);
            v[8*i +: 8] = q;
        end
        cond(1'b1);
    endtask
endmodule

// ### tb/ocf_top_test.sv
// self-checking bench: registers, address decode, pin polarity, fault retry
`timescale 1ns/1ps
module ocf_top_test;
    localparam int MS = 20;

    logic        clock_in  = 1'b0;
    logic        rst_in    = 1'b1;
    logic        scl, sda_low, sda_w, sda_o, sda_oe_n;
    logic [6:0]  strap     = 7'h0a;
    logic        fast_oc   = 1'b0;
    logic        on_off    = 1'b0;
    logic        clr       = 1'b0;
    logic [1:0]  unit      = 2'b00;
    logic        oe, lim, pg, flag, alrt, alrt_oe_n, ok, e;
    logic [6:0]  dev       = 7'h40;
    logic [39:0] v;
    int          err_count = 0;
    int          n_tests   = 0;
    int          r, l, n, uc;
    int          u_ms[4]   = '{1, 4, 16, 256};

    always #5 clock_in = ~clock_in;
    // pull-up: the line is low only while someone pulls it
    assign sda_w = ~sda_low & (sda_oe_n | sda_o);

    ocf_host_model i_host (.clock_in(clock_in), .sda_in(sda_w), .scl_out(scl),
                           .sda_low_out(sda_low));

    ocf_top #(.MS_CYCLES(MS)) i_dut (
        .clock_in(clock_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .addr_strap_in(strap),
        .fast_oc_in(fast_oc), .on_off_in(on_off), .clear_faults_in(clr),
        .iout_delay_unit_in(unit), .output_enable_out(oe), .current_limit_out(lim),
        .power_good_out(pg), .fault_flag_out(flag), .alert_out(alrt),
        .alert_oe_n_out(alrt_oe_n));

    task automatic tick(input int k);
        repeat (k) @(posedge clock_in);
    endtask

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // fault raised for hold cycles; counts restarts and the first off stretch
    task automatic fault_run(input logic [7:0] resp, input logic [1:0] un, input int hold,
                             input int win);
        logic prev;
        prev = 1'b1;
        i_host.write_reg(dev, 8'hca, 1, {32'h0, resp}, ok);
        check(ok, 1'b1);
        unit <= un;
        fast_oc <= 1'b1;
        r = 0;
        l = 0;
        for (int i = 0; i < win; i++) begin
            tick(1);
            if (i == hold) fast_oc <= 1'b0;
            if (i == 8) begin
                check(flag, 1'b1);      // status flag set
                check(alrt_oe_n, 1'b0); // host alerted
                check(alrt, 1'b0);      // alert line pulls low
                check(lim, 1'b1);       // limiting first
            end
            if (oe === 1'b1 && prev === 1'b0) r++;
            if (oe === 1'b0 && r == 0) l++;
            prev = oe;
        end
        e = oe;
        fast_oc <= 1'b0;
        tick(5);
        clr <= 1'b1;
        tick(5);
        clr <= 1'b0;
        tick(5);
        for (int i = 0; i < 300 && oe !== 1'b1; i++) tick(1);
        if (oe !== 1'b1) begin
            err_count++;
            give_verdict();
        end
        check(flag, 1'b0);
        $display("fault test resp=%h unit=%0d done", resp, un);
    endtask

    initial begin
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        tick(5);
        i_host.read_reg(dev, 8'hc9, 5, v, ok);
        check(v, 40'h0040000000);
        i_host.read_reg(dev, 8'hca, 1, v, ok);
        check(v, 40'h0);
        check(oe, 1'b1);                               // low pin is on
        check(pg, 1'b0);                               // good shown low
        i_host.write_reg(dev, 8'hc9, 5, 40'h00200a0000, ok);
        i_host.read_reg(dev, 8'hc9, 5, v, ok);
        check(ok, 1'b0);                               // old address idle
        i_host.read_reg(7'h25, 8'hc9, 5, v, ok);
        check(v, 40'h00200a0000);                      // base plus field
        i_host.write_reg(7'h25, 8'hc9, 5, 40'h81200b0000, ok);
        i_host.read_reg(7'h25, 8'hc9, 5, v, ok);
        check(ok, 1'b0);                               // field offset unused
        dev = 7'h2a;
        i_host.read_reg(dev, 8'hc9, 5, v, ok);
        check(v, 40'h81200b0000);                      // strap offset
        check(oe, 1'b0);                               // low pin now off
        on_off <= 1'b1;
        tick(10);
        check(oe, 1'b1);                               // high pin is on
        check(pg, 1'b1);                               // good shown high
        i_host.write_reg(dev, 8'hc8, 1, 40'h0, ok);
        check(ok, 1'b0);                               // unknown command refused
        $display("register and pin test done");
        fault_run(8'h00, 2'd0, 400, 300);
        check(l, 0);                                   // never off
        check(e, 1'b1);                                // still on
        fault_run(8'h40, 2'd0, 400, 300);
        check(l, 0);                                   // code 01 limits like 00
        check(e, 1'b1);                                // still on
        fault_run(8'hc3, 2'd0, 50, 300);
        check(l, 0);                                   // gone before delay end
        for (int rt = 0; rt < 8; rt++) begin
            fault_run({2'b11, rt[2:0], 3'b000}, 2'd0, -1, 400);
            if (rt == 7) begin
                check(r >= 8, 1'b1);                   // keeps retrying
            end else begin
                check(r, rt);                          // restart count
                check(e, 1'b0);                        // latched off
            end
        end
        for (int k = 0; k < 4; k++) begin
            n = (k == 0) ? 3 : 1;
            uc = MS * u_ms[k];
            fault_run({5'b11001, n[2:0]}, k[1:0], -1, 3 * (1 << n) * uc + 50);
            check(r, 1);                               // one restart
            check(l >= ((1 << n) - 1) * uc && l <= (1 << n) * uc + 4, 1'b1);
            check(e, 1'b0);                            // off after it fails
        end
        give_verdict();
    end
endmodule
